// >>> hdl/rwc_regs.svh
// Register offsets, field positions, reset values and counts for the block.
`ifndef RWC_REGS_SVH
`define RWC_REGS_SVH

// Register offsets on the plain register port.
`define RWC_ADDR_CAUSE 8'h00
`define RWC_ADDR_OPT1 8'h01
`define RWC_ADDR_OPT2 8'h02
`define RWC_ADDR_WCNT 8'h03

// Service keys written to the reset cause address.
`define RWC_KEY_FIRST 8'h55
`define RWC_KEY_SECOND 8'hAA

// Field positions.
`define RWC_OPT1_TSEL_HI 7
`define RWC_OPT1_TSEL_LO 6
`define RWC_OPT2_CLKS_BIT 7
`define RWC_OPT2_WEN_BIT 6

// Reset values of the option fields and of the cause register.
`define RWC_TSEL_RESET 2'h3
`define RWC_CLKS_RESET 1'b0
`define RWC_WEN_RESET 1'b0
`define RWC_CAUSE_POR 8'h80

// Values forced into the processor on every reset.
`define RWC_RESET_VECTOR 16'hFFFE
`define RWC_SP_INIT 16'h00FF

// Default length of the internal reset pulse, in clock cycles.
`define RWC_RST_LEN 16

`endif

// >>> hdl/rwc_pkg.sv
// Types shared by the reset and watchdog control block.
package rwc_pkg;

  // Write-once watchdog settings held by the two option registers.
  typedef struct packed {
    logic [1:0] tsel;
    logic clks;
    logic wen;
  } rwc_opts_t;

  // Reset cause flags; the low bit is unused and reads as zero.
  typedef struct packed {
    logic por;
    logic pin;
    logic wdog;
    logic illegal_opcode_reset;
    logic illegal_address_reset;
    logic clock_loss_reset;
    logic low_voltage_reset;
    logic rsvd;
  } rwc_cause_t;

  typedef enum logic {
    RWC_RUN,
    RWC_HOLD
  } rwc_state_t;

endpackage

// >>> hdl/rwc_sync.sv
// Three-stage input synchroniser with agreement filter, one per bit.
`timescale 1ns/1ps
module rwc_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic q_d;
      logic q_q;

      // The output only moves once stages two and three agree.
      always_comb begin
        q_d = q_q;
        if (s2_q == s3_q) begin
          q_d = s3_q;
        end
      end

      // Stage one feeds stage two alone, so metastability stays contained.
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          s1_q <= RST_VAL[i];
          s2_q <= RST_VAL[i];
          s3_q <= RST_VAL[i];
          q_q <= RST_VAL[i];
        end else begin
          s1_q <= d_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          q_q <= q_d;
        end
      end

      assign q_out[i] = q_q;
    end
  endgenerate

endmodule

// >>> hdl/rwc_top.sv
// Reset sequencing, reset cause recording and service-sequence watchdog.
//
// Function
// - Any reset loads vector, initialises control registers.
// - Reset forces stack pointer to fixed value.
// - Reset sets the global interrupt mask bit.
// - Reset disables peripherals, pins float, no pull-ups.
// - Eight causes; all but debug-forced are recorded.
// - Watchdog enabled after reset; zero select disables.
// - Watchdog expiry generates a system reset.
// - First then second key restarts timeout.
// - Writes leave reset cause register unchanged.
// - Any other value written there resets immediately.
// - Bus clock or 1 kHz source, three timeouts each.
// - Default is 1 kHz source, longest timeout.
// - Windowed service only in final timeout quarter.
// - Early service write in window mode resets.
// - No window mode with the 1 kHz source.
// - Counter initialised on reset and first option writes.
// - Option registers are write-once.
// - Bus clock source freezes count in debug, stop.
// - 1 kHz source clears count in debug, stop.
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "rwc_regs.svh"
module rwc_top #(
  parameter int CNT_W = 18,
  parameter int BUS_LOG1 = 13,
  parameter int BUS_LOG2 = 16,
  parameter int BUS_LOG3 = 18,
  parameter int LPO_LOG1 = 5,
  parameter int LPO_LOG2 = 8,
  parameter int LPO_LOG3 = 10,
  parameter int RST_LEN = `RWC_RST_LEN
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic ext_rst_n_in,
  input wire logic low_voltage_reset_in,
  input wire logic clock_loss_reset_in,
  input wire logic tick_1khz_in,
  input wire logic illegal_opcode_reset_in,
  input wire logic illegal_address_reset_in,
  input wire logic debug_forced_reset_in,
  input wire logic bdm_active_in,
  input wire logic stop_mode_in,
  output logic sys_reset_out,
  output logic pc_load_out,
  output logic [15:0] reset_vector_out,
  output logic [15:0] sp_init_out,
  output logic ccr_imask_set_out,
  output logic periph_disable_out,
  output logic pins_force_input_out,
  output logic pins_pullup_en_out
);

  // Reset bridge: asynchronous assertion, release through two flops.
  logic rb1_q;
  logic rb2_q;
  logic rst_n;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rb1_q <= 1'b0;
      rb2_q <= 1'b0;
    end else begin
      rb1_q <= 1'b1;
      rb2_q <= rb1_q;
    end
  end

  assign rst_n = rb2_q;

  // Pins from other domains: external reset, low voltage, clock loss, tick.
  logic [3:0] pin_sync;
  logic ext_rst_n_s;
  logic lvd_s;
  logic loc_s;
  logic tick_s;

  rwc_sync #(
    .W(4),
    .RST_VAL(4'h8)
  ) u_sync (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .d_in({ext_rst_n_in, low_voltage_reset_in, clock_loss_reset_in,
      tick_1khz_in}),
    .q_out(pin_sync)
  );

  assign ext_rst_n_s = pin_sync[3];
  assign lvd_s = pin_sync[2];
  assign loc_s = pin_sync[1];
  assign tick_s = pin_sync[0];

  // Sequencer, cause, option and watchdog state.
  rwc_pkg::rwc_state_t state_q, state_d;
  logic [15:0] rcnt_q, rcnt_d;
  rwc_pkg::rwc_cause_t cause_q, cause_d;
  rwc_pkg::rwc_opts_t opts_q, opts_d;
  logic lock1_q, lock1_d;
  logic lock2_q, lock2_d;
  logic [CNT_W-1:0] wcnt_q, wcnt_d;
  logic armed_q, armed_d;
  logic tick_dly_q;
  logic [7:0] rdata_q, rdata_d;
  logic sys_reset_q;
  logic pc_load_q;
  logic imask_q;

  // Watchdog decode terms.
  logic [4:0] log_v;
  logic [CNT_W:0] limit;
  logic [CNT_W:0] lim_m1;
  logic [CNT_W:0] win_start;
  logic wdog_on;
  logic windowed;
  logic frozen;
  logic step;
  logic expire;
  logic cause_wr;
  logic key1_wr;
  logic key2_wr;
  logic bad_wr;
  logic early_wr;
  logic service_done;
  logic opt_init;
  logic running;
  rwc_pkg::rwc_cause_t req;

  // Timeout selection per clock source; zero select means disabled.
  always_comb begin
    log_v = 5'(LPO_LOG3);
    case ({opts_q.clks, opts_q.tsel})
      3'b001: log_v = 5'(LPO_LOG1);
      3'b010: log_v = 5'(LPO_LOG2);
      3'b011: log_v = 5'(LPO_LOG3);
      3'b101: log_v = 5'(BUS_LOG1);
      3'b110: log_v = 5'(BUS_LOG2);
      3'b111: log_v = 5'(BUS_LOG3);
      default: log_v = 5'(LPO_LOG3);
    endcase
  end

  // The limit is one bit wider than the count so the top setting fits.
  assign limit = {{CNT_W{1'b0}}, 1'b1} << log_v;
  assign lim_m1 = limit - {{CNT_W{1'b0}}, 1'b1};
  assign win_start = limit - (limit >> 2);
  assign wdog_on = (opts_q.tsel != 2'h0);
  assign windowed = opts_q.clks && opts_q.wen;
  assign frozen = bdm_active_in || stop_mode_in;
  assign step = opts_q.clks ? 1'b1 : (tick_s && !tick_dly_q);
  assign running = (state_q == rwc_pkg::RWC_RUN);
  assign expire = running && wdog_on && !frozen && step &&
    ({1'b0, wcnt_q} == lim_m1);

  // Bus writes to the cause address are service keys or a fault.
  assign cause_wr = running && wr_in && (addr_in == `RWC_ADDR_CAUSE);
  assign key1_wr = cause_wr && (wdata_in == `RWC_KEY_FIRST);
  assign key2_wr = cause_wr && (wdata_in == `RWC_KEY_SECOND);
  assign bad_wr = cause_wr && !key1_wr && !key2_wr;
  assign early_wr = (key1_wr || key2_wr) && wdog_on && windowed &&
    ({1'b0, wcnt_q} < win_start);
  assign service_done = key2_wr && armed_q && !early_wr;
  assign opt_init = running && wr_in &&
    (((addr_in == `RWC_ADDR_OPT1) && !lock1_q) ||
    ((addr_in == `RWC_ADDR_OPT2) && !lock2_q));

  // Gather every reset request seen in this cycle except debug-forced.
  always_comb begin
    req = '0;
    req.pin = !ext_rst_n_s;
    req.wdog = expire || bad_wr || early_wr;
    req.illegal_opcode_reset = illegal_opcode_reset_in;
    req.illegal_address_reset = illegal_address_reset_in;
    req.clock_loss_reset = loc_s;
    req.low_voltage_reset = lvd_s;
  end

  // Reset sequencer: a request starts a hold of RST_LEN cycles.
  always_comb begin
    state_d = state_q;
    rcnt_d = rcnt_q;
    cause_d = cause_q;
    case (state_q)
      rwc_pkg::RWC_RUN: begin
        if ((req != '0) || debug_forced_reset_in) begin
          state_d = rwc_pkg::RWC_HOLD;
          rcnt_d = 16'(RST_LEN - 1);
          cause_d = req;
        end
      end
      rwc_pkg::RWC_HOLD: begin
        if (rcnt_q == 16'h0000) begin
          state_d = rwc_pkg::RWC_RUN;
        end else begin
          rcnt_d = rcnt_q - 16'h0001;
        end
      end
      default: begin
        state_d = rwc_pkg::RWC_HOLD;
      end
    endcase
  end

  // A power-on reset records only the power-on flag.
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= rwc_pkg::RWC_HOLD;
      rcnt_q <= 16'(RST_LEN - 1);
      cause_q <= rwc_pkg::rwc_cause_t'(`RWC_CAUSE_POR);
    end else begin
      state_q <= state_d;
      rcnt_q <= rcnt_d;
      cause_q <= cause_d;
    end
  end

  // Option registers: defaults on every reset, locked after first write.
  always_comb begin
    opts_d = opts_q;
    lock1_d = lock1_q;
    lock2_d = lock2_q;
    if (!running) begin
      opts_d.tsel = `RWC_TSEL_RESET;
      opts_d.clks = `RWC_CLKS_RESET;
      opts_d.wen = `RWC_WEN_RESET;
      lock1_d = 1'b0;
      lock2_d = 1'b0;
    end else if (wr_in) begin
      if ((addr_in == `RWC_ADDR_OPT1) && !lock1_q) begin
        opts_d.tsel = wdata_in[`RWC_OPT1_TSEL_HI:`RWC_OPT1_TSEL_LO];
        lock1_d = 1'b1;
      end
      if ((addr_in == `RWC_ADDR_OPT2) && !lock2_q) begin
        opts_d.clks = wdata_in[`RWC_OPT2_CLKS_BIT];
        opts_d.wen = wdata_in[`RWC_OPT2_WEN_BIT];
        lock2_d = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      opts_q <= '{tsel: `RWC_TSEL_RESET, clks: `RWC_CLKS_RESET,
        wen: `RWC_WEN_RESET};
      lock1_q <= 1'b0;
      lock2_q <= 1'b0;
    end else begin
      opts_q <= opts_d;
      lock1_q <= lock1_d;
      lock2_q <= lock2_d;
    end
  end

  // Watchdog count and service sequence tracking.
  always_comb begin
    wcnt_d = wcnt_q;
    armed_d = armed_q;
    if (key1_wr) begin
      armed_d = 1'b1;
    end else if (cause_wr) begin
      armed_d = 1'b0;
    end
    if (!running || opt_init || service_done) begin
      wcnt_d = '0;
      armed_d = armed_d && running && !service_done;
    end else if (!wdog_on) begin
      wcnt_d = '0;
    end else if (frozen) begin
      if (!opts_q.clks) begin
        wcnt_d = '0;
      end
    end else if (step) begin
      wcnt_d = wcnt_q + {{(CNT_W - 1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      wcnt_q <= '0;
      armed_q <= 1'b0;
      tick_dly_q <= 1'b0;
    end else begin
      wcnt_q <= wcnt_d;
      armed_q <= armed_d;
      tick_dly_q <= tick_s;
    end
  end

  // Read data stand in the cycle after the read strobe only.
  always_comb begin
    rdata_d = 8'h00;
    if (rd_in) begin
      case (addr_in)
        `RWC_ADDR_CAUSE: rdata_d = cause_q;
        `RWC_ADDR_OPT1: rdata_d = {opts_q.tsel, 6'h00};
        `RWC_ADDR_OPT2: rdata_d = {opts_q.clks, opts_q.wen, 6'h00};
        `RWC_ADDR_WCNT: rdata_d = wcnt_q[CNT_W-1 -: 8];
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Processor-facing outputs, all straight from flops.
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
      sys_reset_q <= 1'b1;
      pc_load_q <= 1'b0;
      imask_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      sys_reset_q <= (state_d == rwc_pkg::RWC_HOLD);
      pc_load_q <= !running && (state_d == rwc_pkg::RWC_RUN);
      imask_q <= !running && (state_d == rwc_pkg::RWC_RUN);
    end
  end

  assign rdata_out = rdata_q;
  assign sys_reset_out = sys_reset_q;
  assign pc_load_out = pc_load_q;
  assign ccr_imask_set_out = imask_q;
  assign periph_disable_out = sys_reset_q;
  assign pins_force_input_out = sys_reset_q;

  // Constant load values, held in flops so every output is registered.
  logic [15:0] vec_q;
  logic [15:0] sp_q;
  logic pull_q;

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      vec_q <= `RWC_RESET_VECTOR;
      sp_q <= `RWC_SP_INIT;
      pull_q <= 1'b0;
    end else begin
      vec_q <= `RWC_RESET_VECTOR;
      sp_q <= `RWC_SP_INIT;
      pull_q <= 1'b0;
    end
  end

  assign reset_vector_out = vec_q;
  assign sp_init_out = sp_q;
  assign pins_pullup_en_out = pull_q;

endmodule

// >>> dv/rwc_assertions.sv
// Concurrent checks on the reset and watchdog control ports.
`timescale 1ns/1ps
module rwc_assertions (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic illegal_opcode_reset_in,
  input wire logic illegal_address_reset_in,
  input wire logic debug_forced_reset_in,
  input wire logic sys_reset_out,
  input wire logic pc_load_out,
  input wire logic [15:0] reset_vector_out,
  input wire logic [15:0] sp_init_out,
  input wire logic ccr_imask_set_out,
  input wire logic periph_disable_out,
  input wire logic pins_force_input_out,
  input wire logic pins_pullup_en_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);

  // A write to the cause address with neither key, taken in run.
  sequence s_bad_key;
    wr_in && addr_in == 8'h00 && wdata_in != 8'h55 &&
      wdata_in != 8'hAA && !sys_reset_out;
  endsequence

  // A same-clock fault request seen while the system runs.
  sequence s_fault_req;
    (illegal_opcode_reset_in || illegal_address_reset_in ||
      debug_forced_reset_in) && !sys_reset_out;
  endsequence

  // The release step: reset was high and has just dropped.
  sequence s_release;
    $fell(sys_reset_out);
  endsequence

  chk_vector_const: assert property (reset_vector_out == 16'hFFFE)
    else $error("reset vector differs");
  chk_sp_const: assert property (sp_init_out == 16'h00FF)
    else $error("stack init differs");
  chk_release_load: assert property (
    s_release |-> pc_load_out && ccr_imask_set_out ##1
      !pc_load_out && !ccr_imask_set_out)
    else $error("release pulses wrong");
  chk_pins_safe: assert property (
    sys_reset_out |-> periph_disable_out && pins_force_input_out)
    else $error("pins not safe in reset");
  chk_pullup_off: assert property (!pins_pullup_en_out)
    else $error("pull-up enabled");
  chk_bad_key: assert property (s_bad_key |=> sys_reset_out)
    else $error("bad key did not reset");
  chk_fault_req: assert property (s_fault_req |=> sys_reset_out)
    else $error("fault request did not reset");
  chk_reset_hold: assert property (
    $rose(sys_reset_out) |-> sys_reset_out[*2])
    else $error("reset pulse too short");
  chk_read_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside read slot");
endmodule

bind rwc_top rwc_assertions rwc_assertions_i (.*);

// >>> dv/testbench.sv
// Self-checking bench for the reset and watchdog control block.
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [5:0] src;
    logic [7:0] cause;
  } rwc_row_t;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] addr_in, wdata_in, rdata_out, v;
  logic wr_in, rd_in, ext_rst_n_in, low_voltage_reset_in;
  logic clock_loss_reset_in, tick_1khz_in, illegal_opcode_reset_in;
  logic illegal_address_reset_in, debug_forced_reset_in;
  logic bdm_active_in, stop_mode_in, sys_reset_out, pc_load_out;
  logic [15:0] reset_vector_out, sp_init_out;
  logic ccr_imask_set_out, periph_disable_out, pins_force_input_out;
  logic pins_pullup_en_out, rst_seen;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  // Sources: pin, low voltage, clock loss, opcode, address, debug.
  // A zero source stands for a write of a bad key.
  rwc_row_t rows [7] = '{'{6'h20, 8'h40}, '{6'h10, 8'h02},
    '{6'h08, 8'h04}, '{6'h04, 8'h10}, '{6'h02, 8'h08},
    '{6'h01, 8'h00}, '{6'h00, 8'h20}};

  // Short counts keep the run brief; the checks follow from them.
  // The middle settings and the count width keep their built values.
  rwc_top #(.BUS_LOG1(4), .BUS_LOG3(6), .LPO_LOG1(2), .LPO_LOG3(4),
    .RST_LEN(2)) rwc_top_i (.*);

  // Free-running system clock.
  always #5 mclk_in = ~mclk_in;

  // Latch any reset seen; short pulses would slip past a poll.
  always @(posedge mclk_in) begin
    if (sys_reset_out === 1'b1) rst_seen <= 1'b1;
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      close_out();
    end
  end

  task close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
    // Realign to the edge so later stimulus moves on it.
    @(posedge mclk_in);
  endtask

  // Slow source: one rising edge every six bus cycles.
  task tk(input int n);
    repeat (n) begin
      tick_1khz_in <= 1'b1;
      cyc(3);
      tick_1khz_in <= 1'b0;
      cyc(3);
    end
  endtask

  task clr;
    rst_seen <= 1'b0;
  endtask

  // Wait out a reset, bounded, then clear the latch.
  task recov;
    int i;
    cyc(10);
    for (i = 0; i < 200 && sys_reset_out !== 1'b0; i++) cyc(1);
    cyc(2);
    clr();
  endtask

  task fire(input logic [5:0] s);
    @(posedge mclk_in);
    {ext_rst_n_in, low_voltage_reset_in, clock_loss_reset_in,
      illegal_opcode_reset_in, illegal_address_reset_in,
      debug_forced_reset_in} <= s ^ 6'h20;
    if (s == 6'h00) wr(8'h00, 8'h12);
    cyc(6);
    {ext_rst_n_in, low_voltage_reset_in, clock_loss_reset_in,
      illegal_opcode_reset_in, illegal_address_reset_in,
      debug_forced_reset_in} <= 6'h20;
  endtask

  initial begin
    {addr_in, wdata_in, wr_in, rd_in, low_voltage_reset_in} = '0;
    {clock_loss_reset_in, tick_1khz_in, illegal_opcode_reset_in} = '0;
    {illegal_address_reset_in, debug_forced_reset_in} = '0;
    {bdm_active_in, stop_mode_in, rst_seen} = '0;
    ext_rst_n_in = 1'b1;
    cyc(8);
    chk(sys_reset_out, 1'b1);
    chk(periph_disable_out, 1'b1);
    chk(pins_force_input_out, 1'b1);
    chk(pins_pullup_en_out, 1'b0);
    chk(reset_vector_out, 16'hFFFE);
    chk(sp_init_out, 16'h00FF);
    nrst_in <= 1'b1;
    recov();
    rd(8'h00);
    chk(v, 8'h80);
    foreach (rows[k]) begin
      fire(rows[k].src);
      recov();
      rd(8'h00);
      chk(v, rows[k].cause);
    end
    // Default slow source, third setting: expires on the sixteenth step.
    tk(15);
    chk(rst_seen, 1'b0);
    tk(2);
    chk(rst_seen, 1'b1);
    recov();
    // A lone second key is harmless; a key pair restarts the count.
    wr(8'h00, 8'hAA);
    tk(12);
    wr(8'h00, 8'h55);
    wr(8'h00, 8'hAA);
    rd(8'h00);
    chk(v, 8'h20);
    tk(12);
    chk(rst_seen, 1'b0);
    tk(6);
    chk(rst_seen, 1'b1);
    recov();
    // The first option write wins; the second is ignored.
    wr(8'h01, 8'h40);
    wr(8'h01, 8'hC0);
    rd(8'h01);
    chk(v, 8'h40);
    clr();
    tk(3);
    chk(rst_seen, 1'b0);
    tk(2);
    chk(rst_seen, 1'b1);
    recov();
    wr(8'h01, 8'h00);
    wr(8'h01, 8'h40);
    tk(20);
    chk(rst_seen, 1'b0);
    wr(8'h00, 8'h00);
    recov();
    // Middle slow setting at its built length, then the short bus setting.
    wr(8'h01, 8'h80);
    tk(255);
    chk(rst_seen, 1'b0);
    tk(2);
    chk(rst_seen, 1'b1);
    recov();
    wr(8'h02, 8'h80);
    wr(8'h01, 8'h40);
    clr();
    cyc(14);
    chk(rst_seen, 1'b0);
    cyc(4);
    chk(rst_seen, 1'b1);
    recov();
    // Windowed bus-clock mode, sixty-four cycle period.
    wr(8'h02, 8'hC0);
    wr(8'h01, 8'hC0);
    clr();
    cyc(52);
    wr(8'h00, 8'h55);
    wr(8'h00, 8'hAA);
    cyc(40);
    chk(rst_seen, 1'b0);
    wr(8'h00, 8'h55);
    cyc(3);
    chk(rst_seen, 1'b1);
    recov();
    rd(8'h00);
    chk(v, 8'h20);
    // Window bit has no effect on the slow source.
    wr(8'h02, 8'h40);
    clr();
    wr(8'h00, 8'h55);
    wr(8'h00, 8'hAA);
    cyc(5);
    chk(rst_seen, 1'b0);
    tk(10);
    stop_mode_in <= 1'b1;
    cyc(4);
    stop_mode_in <= 1'b0;
    tk(10);
    chk(rst_seen, 1'b0);
    tk(7);
    chk(rst_seen, 1'b1);
    recov();
    // Bus-clock source holds its count through debug mode.
    wr(8'h02, 8'h80);
    wr(8'h01, 8'hC0);
    clr();
    cyc(40);
    bdm_active_in <= 1'b1;
    cyc(100);
    bdm_active_in <= 1'b0;
    cyc(20);
    chk(rst_seen, 1'b0);
    cyc(12);
    chk(rst_seen, 1'b1);
    // A second power-on reset in mid-run records only the power-on flag.
    nrst_in <= 1'b0;
    cyc(2);
    chk(sys_reset_out, 1'b1);
    nrst_in <= 1'b1;
    recov();
    rd(8'h00);
    chk(v, 8'h80);
    close_out();
  end
endmodule
